// ==== design/literal_and_table_op_decoder.sv ====
// Decode and execute of literal and program-memory table instructions
// Contract
// RULE1: Add immediate adds literal to working register, updating all five flags.
// RULE2: And immediate ANDs literal into working register; only zero and negative change.
// RULE3: Or immediate ORs literal into working register; only zero and negative change.
// RULE4: Xor immediate XORs literal into working register; only zero and negative change.
// RULE5: Reverse subtract puts literal minus working register there, updating all flags.
// RULE6: Load immediate puts literal in working register, flags untouched.
// RULE7: Load bank immediate writes four literal bits to bank select, no flags.
// RULE8: Multiply immediate multiplies literal by working register in one cycle, no flags.
// RULE9: Return with immediate loads literal, returns, takes two cycles, no flags.
// RULE10: Two-word pointer load sets a 12-bit indirect pointer over two cycles.
// RULE11: Table reads take two cycles into the latch with four pointer modes.
// RULE12: Table writes take two cycles from the latch with four pointer modes.
// RULE13: Port read-modify-write uses sampled pin levels, not output latch.
// RULE14: Writing the timer zero count clears its prescaler when assigned.
// RULE15: Flow change or true test costs two cycles, second one a no-op.
// RULE16: A stray second word of a two-word instruction runs as no-op.
// RULE17: Table accesses use a 21-bit table pointer that the mode updates.
// RULE18: Multiply result goes to product high and low, not working register.
// RULE19: Subtract carry means no borrow; digit carry likewise for bit three.
`timescale 1ns/1ps
`default_nettype none
module literal_and_table_op_decoder
    import lit_table_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic flow_change_i,
    input wire logic [DATA_W-1:0] tbl_rdata_i,
    input wire logic port_rmw_i,
    input wire logic [DATA_W-1:0] port_pins_i,
    input wire logic [DATA_W-1:0] port_latch_i,
    input wire logic timer_zero_count_write_i,
    input wire logic prescaler_assigned_i,
    output logic stall_o,
    output logic second_word_nop_o,
    output logic return_o,
    output logic [DATA_W-1:0] working_register_o,
    output logic [BANK_W-1:0] bank_select_register_o,
    output logic [IND_W-1:0] indirect_pointer0_o,
    output logic [IND_W-1:0] indirect_pointer1_o,
    output logic [IND_W-1:0] indirect_pointer2_o,
    output logic [PTR_W-1:0] table_pointer_o,
    output logic [DATA_W-1:0] table_latch_o,
    output logic [DATA_W-1:0] product_high_o,
    output logic [DATA_W-1:0] product_low_o,
    output logic carry_o,
    output logic digit_carry_o,
    output logic zero_o,
    output logic signed_wrap_flag_o,
    output logic negative_o,
    output logic tbl_rd_o,
    output logic tbl_wr_o,
    output logic [PTR_W-1:0] tbl_addr_o,
    output logic [DATA_W-1:0] port_operand_o,
    output logic prescaler_clear_o
);
    typedef struct packed {
        state_t st;
        logic [DATA_W-1:0] work;
        logic [BANK_W-1:0] bank;
        logic [NUM_IND-1:0][IND_W-1:0] ind;
        logic [1:0] ptr_sel;
        logic [3:0] ptr_hi;
        logic [PTR_W-1:0] tbl_ptr;
        logic [DATA_W-1:0] tbl_latch;
        logic [DATA_W-1:0] prod_hi;
        logic [DATA_W-1:0] prod_lo;
        logic c;
        logic dig;
        logic z;
        logic wrap;
        logic n;
        logic tbl_rd;
        logic tbl_wr;
        logic [PTR_W-1:0] tbl_addr;
        logic ret;
        logic stall;
        logic nop;
        logic presc_clr;
        logic [DATA_W-1:0] port_opnd;
    } core_state_t;

    core_state_t q;
    core_state_t d;

    alu_op_t alu_op;
    logic [DATA_W-1:0] alu_res;
    logic alu_c;
    logic alu_dig;
    logic alu_z;
    logic alu_wrap;
    logic alu_n;
    logic [2*DATA_W-1:0] alu_prod;
    logic [7:0] hi;
    logic [7:0] lit;
    logic exec;

    function automatic logic [PTR_W-1:0] ptr_after(input logic [PTR_W-1:0] p,
                                                   input logic [1:0] mode);
        case (mode)
            MODE_POST_INC: ptr_after = p + 21'h000001;
            MODE_PRE_INC: ptr_after = p + 21'h000001;
            MODE_POST_DEC: ptr_after = p - 21'h000001;
            default: ptr_after = p;
        endcase
    endfunction

    assign hi = instr_i[15:8];
    assign lit = instr_i[7:0];
    assign exec = instr_valid_i && (q.st == ST_EXEC) && !flow_change_i;

    always_comb
    begin
        case (hi)
            OP_SUB: alu_op = ALU_SUB;
            OP_AND: alu_op = ALU_AND;
            OP_IOR: alu_op = ALU_IOR;
            OP_XOR: alu_op = ALU_XOR;
            default: alu_op = ALU_ADD;
        endcase
    end

    literal_alu literal_alu_inst (
        .op_i(alu_op),
        .lit_i(lit),
        .work_i(q.work),
        .result_o(alu_res),
        .carry_o(alu_c),
        .digit_carry_o(alu_dig),
        .zero_o(alu_z),
        .signed_wrap_flag_o(alu_wrap),
        .negative_o(alu_n),
        .product_o(alu_prod)
    );

    always_comb
    begin
        d = q;
        d.tbl_rd = 1'b0;
        d.tbl_wr = 1'b0;
        d.ret = 1'b0;
        d.stall = 1'b0;
        d.nop = 1'b0;
        d.presc_clr = timer_zero_count_write_i && prescaler_assigned_i; // [RULE14]
        d.port_opnd = port_rmw_i ? port_pins_i : port_latch_i; // [RULE13]
        case (q.st)
            ST_EXEC:
            begin
                if (instr_valid_i && flow_change_i)
                begin
                    d.st = ST_FLUSH; // [RULE15]
                    d.stall = 1'b1;
                end
                else if (instr_valid_i)
                begin
                    case (hi)
                        OP_ADD, OP_SUB:
                        begin
                            d.work = alu_res; // [RULE1] [RULE5]
                            d.c = alu_c; // [RULE19]
                            d.dig = alu_dig;
                            d.z = alu_z;
                            d.wrap = alu_wrap;
                            d.n = alu_n;
                        end
                        OP_AND, OP_IOR, OP_XOR:
                        begin
                            d.work = alu_res; // [RULE2] [RULE3] [RULE4]
                            d.z = alu_z;
                            d.n = alu_n;
                        end
                        OP_MOV: d.work = lit; // [RULE6]
                        OP_MUL:
                        begin
                            d.prod_hi = alu_prod[15:8]; // [RULE8] [RULE18]
                            d.prod_lo = alu_prod[7:0];
                        end
                        OP_RET:
                        begin
                            d.work = lit; // [RULE9]
                            d.ret = 1'b1;
                            d.st = ST_FLUSH;
                            d.stall = 1'b1;
                        end
                        OP_BANK:
                        begin
                            if (instr_i[7:4] == NIB_ZERO)
                            begin
                                d.bank = instr_i[3:0]; // [RULE7]
                            end
                        end
                        OP_PTR1:
                        begin
                            // Reserved pointer code 3 still swallows its second word
                            if (instr_i[7:6] == PTR_SEL_HI)
                            begin
                                d.ptr_sel = instr_i[5:4]; // [RULE10]
                                d.ptr_hi = instr_i[3:0];
                                d.st = ST_PTR2;
                            end
                        end
                        OP_ZERO:
                        begin
                            if (instr_i[7:4] == NIB_ZERO &&
                                (instr_i[3:2] == TBL_READ || instr_i[3:2] == TBL_WRITE))
                            begin
                                // Pre-increment addresses the advanced pointer
                                d.tbl_addr = (instr_i[1:0] == MODE_PRE_INC) ?
                                    ptr_after(q.tbl_ptr, instr_i[1:0]) : q.tbl_ptr; // [RULE17]
                                d.tbl_ptr = ptr_after(q.tbl_ptr, instr_i[1:0]); // [RULE17]
                                d.tbl_rd = (instr_i[3:2] == TBL_READ); // [RULE11]
                                d.tbl_wr = (instr_i[3:2] == TBL_WRITE); // [RULE12]
                                d.st = ST_TBL2;
                                d.stall = 1'b1;
                            end
                        end
                        default:
                        begin
                            d.nop = (instr_i[15:12] == NIB_SECOND); // [RULE16]
                        end
                    endcase
                end
            end
            ST_PTR2:
            begin
                if (instr_valid_i)
                begin
                    // A word that is not an operand word abandons the load
                    if (hi == OP_PTR2 && q.ptr_sel < 2'(NUM_IND))
                    begin
                        d.ind[q.ptr_sel] = {q.ptr_hi, lit}; // [RULE10]
                    end
                    d.st = ST_EXEC;
                end
            end
            ST_TBL2:
            begin
                if (q.tbl_rd)
                begin
                    d.tbl_latch = tbl_rdata_i; // [RULE11]
                end
                d.st = ST_EXEC;
            end
            ST_FLUSH: d.st = ST_EXEC; // [RULE15]
            default: d.st = ST_EXEC;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q <= '0;
            q.st <= ST_EXEC;
        end
        else
        begin
            q <= d;
        end
    end

    assign stall_o = q.stall;
    assign second_word_nop_o = q.nop;
    assign return_o = q.ret;
    assign working_register_o = q.work;
    assign bank_select_register_o = q.bank;
    assign indirect_pointer0_o = q.ind[0];
    assign indirect_pointer1_o = q.ind[1];
    assign indirect_pointer2_o = q.ind[2];
    assign table_pointer_o = q.tbl_ptr;
    assign table_latch_o = q.tbl_latch;
    assign product_high_o = q.prod_hi;
    assign product_low_o = q.prod_lo;
    assign carry_o = q.c;
    assign digit_carry_o = q.dig;
    assign zero_o = q.z;
    assign signed_wrap_flag_o = q.wrap;
    assign negative_o = q.n;
    assign tbl_rd_o = q.tbl_rd;
    assign tbl_wr_o = q.tbl_wr;
    assign tbl_addr_o = q.tbl_addr;
    assign port_operand_o = q.port_opnd;
    assign prescaler_clear_o = q.presc_clr;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    add_result_a: assert property (exec && hi == OP_ADD |=> // [RULE1]
        working_register_o == $past(8'(lit + q.work)) &&
        carry_o == ($past(9'(lit) + 9'(q.work)) > 9'hff))
        else $error("add immediate result or carry wrong");

    and_flags_a: assert property (exec && hi == OP_AND |=> // [RULE2]
        working_register_o == $past(lit & q.work) &&
        $stable(carry_o) && $stable(signed_wrap_flag_o))
        else $error("and immediate wrong or touched arithmetic flags");

    or_result_a: assert property (exec && hi == OP_IOR |=> // [RULE3]
        working_register_o == $past(lit | q.work) && zero_o == (working_register_o == 8'h00))
        else $error("or immediate result or zero flag wrong");

    xor_result_a: assert property (exec && hi == OP_XOR |=> // [RULE4]
        working_register_o == $past(lit ^ q.work) && negative_o == working_register_o[7])
        else $error("xor immediate result or negative flag wrong");

    sub_borrow_a: assert property (exec && hi == OP_SUB |=> // [RULE5] [RULE19]
        working_register_o == $past(8'(lit - q.work)) && carry_o == $past(lit >= q.work))
        else $error("reverse subtract result or borrow sense wrong");

    mul_product_a: assert property (exec && hi == OP_MUL |=> // [RULE8] [RULE18]
        {product_high_o, product_low_o} == $past(16'(lit) * 16'(q.work)) &&
        $stable(working_register_o))
        else $error("multiply product wrong or working register changed");

    ret_two_cycle_a: assert property (exec && hi == OP_RET |=> // [RULE9]
        return_o && stall_o && working_register_o == $past(lit) ##1 !stall_o && !return_o)
        else $error("return with immediate not two cycles");

    table_read_a: assert property (exec && instr_i == 16'h0008 |=> // [RULE11]
        tbl_rd_o && tbl_addr_o == $past(q.tbl_ptr) ##1
        !tbl_rd_o && table_latch_o == $past(tbl_rdata_i))
        else $error("table read sequence wrong");

    flush_nop_a: assert property (exec && hi[7:4] == NIB_SECOND |=> // [RULE16]
        second_word_nop_o && $stable(working_register_o) && $stable(table_pointer_o))
        else $error("stray second word changed state");

    prescaler_a: assert property (timer_zero_count_write_i && prescaler_assigned_i |=> // [RULE14]
        prescaler_clear_o)
        else $error("prescaler not cleared on timer write");
endmodule
`default_nettype wire

// ==== design/lit_table_pkg.sv ====
// Opcode patterns, field positions and reset values for the literal and table decoder
package lit_table_pkg;
    localparam int DATA_W = 8;
    localparam int PTR_W = 21;
    localparam int IND_W = 12;
    localparam int NUM_IND = 3;
    localparam int BANK_W = 4;

    // Upper byte of literal, two-word pointer load and table instructions
    localparam logic [7:0] OP_ADD = 8'h0f;
    localparam logic [7:0] OP_AND = 8'h0b;
    localparam logic [7:0] OP_IOR = 8'h09;
    localparam logic [7:0] OP_XOR = 8'h0a;
    localparam logic [7:0] OP_SUB = 8'h08;
    localparam logic [7:0] OP_MOV = 8'h0e;
    localparam logic [7:0] OP_MUL = 8'h0d;
    localparam logic [7:0] OP_RET = 8'h0c;
    localparam logic [7:0] OP_BANK = 8'h01;
    localparam logic [7:0] OP_PTR1 = 8'hee;
    localparam logic [7:0] OP_PTR2 = 8'hf0;
    localparam logic [7:0] OP_ZERO = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_SECOND = 4'hf;
    localparam logic [1:0] PTR_SEL_HI = 2'h0;

    // Table group: bits 3:2 of a word whose upper 12 bits are zero
    localparam logic [1:0] TBL_READ = 2'h2;
    localparam logic [1:0] TBL_WRITE = 2'h3;

    // Table pointer modes in bits 1:0
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;

    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [PTR_W-1:0] RST_PTR = 21'h000000;
    localparam logic [IND_W-1:0] RST_IND = 12'h000;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_AND = 3'h2,
        ALU_IOR = 3'h3,
        ALU_XOR = 3'h4
    } alu_op_t;

    typedef enum logic [3:0] {
        ST_EXEC = 4'b0001,
        ST_PTR2 = 4'b0010,
        ST_TBL2 = 4'b0100,
        ST_FLUSH = 4'b1000
    } state_t;
endpackage

// ==== design/literal_alu.sv ====
// Combinational literal arithmetic, logic and multiply unit
`timescale 1ns/1ps
`default_nettype none
module literal_alu
    import lit_table_pkg::*;
(
    input wire alu_op_t op_i,
    input wire logic [DATA_W-1:0] lit_i,
    input wire logic [DATA_W-1:0] work_i,
    output logic [DATA_W-1:0] result_o,
    output logic carry_o,
    output logic digit_carry_o,
    output logic zero_o,
    output logic signed_wrap_flag_o,
    output logic negative_o,
    output logic [2*DATA_W-1:0] product_o
);
    logic [DATA_W-1:0] b;
    logic cin;
    logic [DATA_W:0] sum;
    logic [4:0] low;

    always_comb
    begin
        // Reverse subtract is literal plus inverted working value plus one
        b = (op_i == ALU_SUB) ? ~work_i : work_i;
        cin = (op_i == ALU_SUB);
        sum = {1'b0, lit_i} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, lit_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        case (op_i)
            ALU_AND: result_o = lit_i & work_i;
            ALU_IOR: result_o = lit_i | work_i;
            ALU_XOR: result_o = lit_i ^ work_i;
            default: result_o = sum[DATA_W-1:0];
        endcase
        // Carry out of the sum is set on no borrow for subtraction
        carry_o = sum[DATA_W];
        digit_carry_o = low[4];
        signed_wrap_flag_o = (lit_i[7] == b[7]) && (sum[7] != lit_i[7]);
        zero_o = (result_o == RST_BYTE);
        negative_o = result_o[DATA_W-1];
        product_o = {8'h00, lit_i} * {8'h00, work_i};
    end
endmodule
`default_nettype wire

// ==== tb/prog_mem_model.sv ====
// Program memory model: answers table reads and captures table writes
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
    import lit_table_pkg::*;
(
    input wire logic clock_i,
    input wire logic tbl_rd_i,
    input wire logic tbl_wr_i,
    input wire logic [PTR_W-1:0] tbl_addr_i,
    input wire logic [DATA_W-1:0] tbl_wdata_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic [DATA_W-1:0] wr_data_o
);
    logic [DATA_W-1:0] last_q = 8'h00;
    // Released bus shows the inverse of the last byte, so a late sample is caught
    always_comb
    begin
        rdata_o = tbl_rd_i ? (tbl_addr_i[7:0] ^ 8'h5a) : ~last_q;
    end
    always_ff @(posedge clock_i)
    begin
        if (tbl_rd_i)
        begin
            last_q <= rdata_o;
        end
        if (tbl_wr_i)
        begin
            wr_data_o <= tbl_wdata_i;
        end
    end
endmodule
`default_nettype wire

// ==== tb/literal_and_table_op_decoder_tb.sv ====
// Self-checking bench for the literal and table instruction decoder
`timescale 1ns/1ps
`default_nettype none
module literal_and_table_op_decoder_tb
    import lit_table_pkg::*;
;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic flow_change_i = 1'b0;
    logic port_rmw_i = 1'b0;
    logic timer_zero_count_write_i = 1'b0;
    logic prescaler_assigned_i = 1'b0;
    logic [DATA_W-1:0] port_pins_i = 8'h3c;
    logic [DATA_W-1:0] port_latch_i = 8'hc3;
    logic [DATA_W-1:0] tbl_rdata_i, wr_data, working_register_o, table_latch_o;
    logic [DATA_W-1:0] product_high_o, product_low_o, port_operand_o;
    logic stall_o, second_word_nop_o, return_o, tbl_rd_o, tbl_wr_o, prescaler_clear_o;
    logic carry_o, digit_carry_o, zero_o, signed_wrap_flag_o, negative_o;
    logic [BANK_W-1:0] bank_select_register_o;
    logic [IND_W-1:0] indirect_pointer0_o, indirect_pointer1_o, indirect_pointer2_o;
    logic [PTR_W-1:0] table_pointer_o, tbl_addr_o, p, np, a;
    logic [4:0] fl;
    logic [15:0] w;
    logic [7:0] lat;
    int errors = 0;
    int cmp_count = 0;
    // Entries: word, expected working register, expected carry/digit/zero/wrap/negative
    logic [28:0] alu_tab [11] = '{{16'h0e7f, 8'h7f, 5'b00000}, {16'h0f01, 8'h80, 5'b01011},
        {16'h0f80, 8'h00, 5'b10110}, {16'h0e55, 8'h55, 5'b10110}, {16'h0b0f, 8'h05, 5'b10010},
        {16'h0980, 8'h85, 5'b10011}, {16'h0a85, 8'h00, 5'b10110}, {16'h0e05, 8'h05, 5'b10110},
        {16'h0803, 8'hfe, 5'b00001}, {16'h087f, 8'h81, 5'b01011}, {16'h0881, 8'h00, 5'b11100}};

    assign fl = {carry_o, digit_carry_o, zero_o, signed_wrap_flag_o, negative_o};

    literal_and_table_op_decoder literal_and_table_op_decoder_inst (
        .clock_i(clock_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .flow_change_i(flow_change_i), .tbl_rdata_i(tbl_rdata_i),
        .port_rmw_i(port_rmw_i), .port_pins_i(port_pins_i), .port_latch_i(port_latch_i),
        .timer_zero_count_write_i(timer_zero_count_write_i),
        .prescaler_assigned_i(prescaler_assigned_i), .stall_o(stall_o),
        .second_word_nop_o(second_word_nop_o), .return_o(return_o),
        .working_register_o(working_register_o), .bank_select_register_o(bank_select_register_o),
        .indirect_pointer0_o(indirect_pointer0_o), .indirect_pointer1_o(indirect_pointer1_o),
        .indirect_pointer2_o(indirect_pointer2_o), .table_pointer_o(table_pointer_o),
        .table_latch_o(table_latch_o), .product_high_o(product_high_o),
        .product_low_o(product_low_o), .carry_o(carry_o), .digit_carry_o(digit_carry_o),
        .zero_o(zero_o), .signed_wrap_flag_o(signed_wrap_flag_o), .negative_o(negative_o),
        .tbl_rd_o(tbl_rd_o), .tbl_wr_o(tbl_wr_o), .tbl_addr_o(tbl_addr_o),
        .port_operand_o(port_operand_o), .prescaler_clear_o(prescaler_clear_o));

    prog_mem_model prog_mem_model_inst (
        .clock_i(clock_i), .tbl_rd_i(tbl_rd_o), .tbl_wr_i(tbl_wr_o), .tbl_addr_i(tbl_addr_o),
        .tbl_wdata_i(table_latch_o), .rdata_o(tbl_rdata_i), .wr_data_o(wr_data));

    always #25 clock_i = ~clock_i;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs change on the falling edge, away from the sampling edge
    task automatic step(input logic [15:0] wd, input logic v, input logic f);
        @(negedge clock_i);
        instr_i = wd;
        instr_valid_i = v;
        flow_change_i = f;
    endtask

    // One word, then idle; returns in the cycle after the taking edge
    task automatic op(input logic [15:0] wd);
        step(wd, 1'b1, 1'b0);
        step(16'h0000, 1'b0, 1'b0);
    endtask

    task automatic note(input string s);
        $display("test %s done, mismatches so far %0d", s, errors);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        chk(table_pointer_o, 21'h000000);
        for (int i = 0; i < 11; i++)
        begin
            op(alu_tab[i][28:13]);
            chk(working_register_o, alu_tab[i][12:5]);
            chk(fl, alu_tab[i][4:0]);
        end
        note("literal alu");
        step(16'h0efe, 1'b1, 1'b0);
        op(16'h0d03);
        chk({product_high_o, product_low_o, working_register_o}, 24'h02fafe);
        op(16'h0109);
        op(16'h0119);
        chk({bank_select_register_o, fl}, {4'h9, 5'b11100});
        note("multiply and bank");
        step(16'h0c07, 1'b1, 1'b0);
        step(16'h0f01, 1'b1, 1'b0);
        chk({working_register_o, return_o, stall_o, fl}, {8'h07, 2'b11, 5'b11100});
        op(16'h0f01);
        chk({working_register_o, return_o, stall_o, fl}, {8'h08, 7'b0});
        step(16'h0f01, 1'b1, 1'b1);
        step(16'h0000, 1'b0, 1'b0);
        chk({working_register_o, stall_o}, {8'h08, 1'b1});
        note("return and flow change");
        for (int f = 0; f < 3; f++)
        begin
            step({8'hee, 2'b00, 2'(f), 4'(f + 5)}, 1'b1, 1'b0);
            op({8'hf0, 8'(8'h30 + f)});
        end
        step(16'hee3f, 1'b1, 1'b0);
        op(16'hf0ff);
        chk({indirect_pointer2_o, indirect_pointer1_o, indirect_pointer0_o},
            {12'h732, 12'h631, 12'h530});
        op(16'hf012);
        chk({second_word_nop_o, working_register_o}, {1'b1, 8'h08});
        note("pointer load");
        p = 21'h000000;
        lat = 8'h00;
        for (int i = 0; i < 9; i++)
        begin
            w = (i == 0) ? 16'h000a : 16'(7 + i);
            a = (w[1:0] == MODE_PRE_INC) ? p + 21'h1 : p;
            np = (w[1:0] == MODE_POST_INC || w[1:0] == MODE_PRE_INC) ? p + 21'h1 :
                 (w[1:0] == MODE_POST_DEC) ? p - 21'h1 : p;
            op(w);
            chk({stall_o, tbl_rd_o, tbl_wr_o}, {1'b1, ~w[2], w[2]});
            chk({tbl_addr_o, table_pointer_o}, {a, np});
            step(16'h0000, 1'b0, 1'b0);
            if (!w[2])
                lat = a[7:0] ^ 8'h5a;
            chk({stall_o, table_latch_o}, {1'b0, lat});
            if (w[2])
                chk(wr_data, lat);
            p = np;
        end
        note("table access");
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock_i);
            port_rmw_i = i[0];
            timer_zero_count_write_i = i[0];
            prescaler_assigned_i = i[1];
            @(negedge clock_i);
            chk(port_operand_o, i[0] ? port_pins_i : port_latch_i);
            chk(prescaler_clear_o, i[0] & i[1]);
        end
        note("port and timer");
        give_verdict();
    end

    // Hang guard: a run this long means a stuck sequence
    initial
    begin
        repeat (5000) @(posedge clock_i);
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
